// ### mag_assertions.sv
// Purpose: Wire-level checks on the two-wire link.
// Assumes: Controller quarter period of at least 9 clk.
// Notes:   Sees only the link, so byte contents are judged by the bench.
`timescale 1ns/1ps
module mag_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Link
   input wire logic host_scl_oe,
   input wire logic host_scl_out,
   input wire logic host_sda_oe,
   input wire logic host_sda_out,
   input wire logic dev_scl_oe,
   input wire logic dev_sda_oe,
   input wire logic dev_sda_out,
   input wire logic scl
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_start;
      scl && $rose(host_sda_oe);
   endsequence
   sequence s_stop;
      scl && $fell(host_sda_oe);
   endsequence
   AST_DEV_SCL: assert property (!dev_scl_oe)
      else $error("sensor pulled scl");
   AST_DEV_OUT: assert property (dev_sda_oe |-> !dev_sda_out)
      else $error("sensor drives sda high");
   AST_HOST_OUT: assert property ((host_sda_oe || host_scl_oe) |-> !(host_sda_out || host_scl_out))
      else $error("controller drives a line high");
   // A sensor change while scl is high would look like a start or stop
   AST_DEV_HOLD: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("sensor moved sda with scl high");
   AST_DEV_ROSE: assert property ($rose(dev_sda_oe) |-> !scl)
      else $error("sensor pulled sda outside scl low");
   AST_START: assert property (s_start |=> scl [*8])
      else $error("start too short");
   AST_STOP: assert property (s_stop |=> !host_scl_oe [*8])
      else $error("bus not free after stop");
   AST_LOW: assert property ($fell(scl) |=> !scl [*8])
      else $error("scl low phase too short");
endmodule

// ### mag_consts.svh
// Purpose: Shared constants of the magnetometer command link.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef MAG_CONSTS_SVH
`define MAG_CONSTS_SVH

`define MAG_DEV_ADDR        7'h10
`define MAG_CMD_MEASURE     8'hAA
`define MAG_CMD_CHECKSUM    8'h90
`define MAG_MEM_WR_BIT      6
`define MAG_MEM_CMD_BIT     7
`define MAG_ST_POWER_BIT    6
`define MAG_ST_BUSY_BIT     5
`define MAG_ST_MEMERR_BIT   2
`define MAG_ST_SAT_BIT      0
`define MAG_MEAS_LEN        3'h7
`define MAG_MEM_LEN         3'h3
`define MAG_WR_LEN          2'h3
`define MAG_IDLE_BYTE       8'hFF
`define MAG_FIFO_DEPTH      8
`define MAG_CLK_PERIOD_NS   10
`define MAG_SCL_PERIOD_NS   2500
`define MAG_QUARTER_CYCLES  ((`MAG_SCL_PERIOD_NS / `MAG_CLK_PERIOD_NS) / 4)

`endif

// ### mag_ctrl_end.sv
// Purpose: Controller end of the two-wire command link (bus master).
// Assumes: Only this end drives scl; the sensor never stretches it.
// Notes:   Read bytes pass a FIFO; a full FIFO holds scl low.
`timescale 1ns/1ps
`include "mag_consts.svh"
module mag_ctrl_end #(
   parameter int QUARTER_CYCLES = `MAG_QUARTER_CYCLES,
   parameter int FIFO_DEPTH     = `MAG_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Two-wire link
   mag_if.host_mp           link,
   // Transfer request
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_read,
   input  wire logic [2:0]  req_len,
   input  wire logic [23:0] req_bytes,
   // Completion
   output logic             done,
   output logic             nack_err,
   // Received bytes
   output logic             rx_valid,
   input  wire logic        rx_ready,
   output logic [7:0]       rx_data
);
   import mag_pkg::*;

   mag_host_state_type state;
   logic [15:0]        div_cnt;
   logic [1:0]         sda_sync;
   logic [1:0]         phase;
   logic [3:0]         bitn;
   logic [2:0]         byten;
   logic [2:0]         len_q;
   logic               rd_q;
   logic [23:0]        pay_q;
   logic [7:0]         sh;
   logic               ack_q;
   logic               retry_q;
   logic               scl_oe;
   logic               sda_oe;
   logic               fifo_ready;

   wire       tick      = div_cnt == 16'(QUARTER_CYCLES - 1);
   wire       sda_s     = sda_sync[1];
   wire       is_rx     = rd_q & (byten != 3'h0);
   wire       last      = byten == len_q;
   wire       busy_st   = (byten == 3'h1) & sh[`MAG_ST_BUSY_BIT];
   wire       ack_slot  = bitn == 4'h8;
   wire       stall     = is_rx & (bitn == 4'h0) & ~fifo_ready;
   wire       bit_step  = (state == MAG_HS_BIT) & tick;
   wire       push      = bit_step & (phase == 2'h3) & ack_slot & is_rx & ~busy_st;
   wire [7:0] addr_byte = {`MAG_DEV_ADDR, rd_q};
   wire [7:0] pay_pick  = pay_q[5'd23 - {byten[1:0], 3'b000} -: 8];

   assign req_ready         = state == MAG_HS_IDLE;
   assign link.host_scl_oe  = scl_oe;
   assign link.host_sda_oe  = sda_oe;
   assign link.host_scl_out = 1'b0;
   assign link.host_sda_out = 1'b0;

   mag_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) rx_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .in_data   (sh),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         div_cnt  <= 16'h0000;
         sda_sync <= 2'h3;
      end else begin
         div_cnt  <= (tick | (state == MAG_HS_IDLE)) ? 16'h0000 : div_cnt + 16'h0001;
         sda_sync <= {sda_sync[0], link.sda};
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state    <= MAG_HS_IDLE;
         phase    <= 2'h0;
         bitn     <= 4'h0;
         byten    <= 3'h0;
         len_q    <= 3'h0;
         rd_q     <= 1'b0;
         pay_q    <= 24'h000000;
         sh       <= 8'h00;
         ack_q    <= 1'b0;
         retry_q  <= 1'b0;
         scl_oe   <= 1'b0;
         sda_oe   <= 1'b0;
         done     <= 1'b0;
         nack_err <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            MAG_HS_IDLE: begin
               phase <= 2'h0;
               if (req_valid) begin
                  state    <= MAG_HS_START;
                  rd_q     <= req_read;
                  len_q    <= req_len;
                  pay_q    <= req_bytes;
                  nack_err <= 1'b0;
               end
            end
            MAG_HS_START: begin
               if (tick) begin
                  phase <= phase + 2'h1;
                  if (phase == 2'h0) begin
                     sda_oe <= 1'b1;
                  end else begin
                     scl_oe <= 1'b1;
                     state  <= MAG_HS_BIT;
                     phase  <= 2'h0;
                     bitn   <= 4'h0;
                     byten  <= 3'h0;
                     sh     <= addr_byte;
                  end
               end
            end
            MAG_HS_BIT: begin
               if (tick & ~((phase == 2'h0) & stall)) begin
                  phase <= phase + 2'h1;
                  case (phase)
                     2'h0: begin
                        if (ack_slot) begin
                           sda_oe <= is_rx & ~(last | busy_st);
                        end else begin
                           sda_oe <= ~is_rx & ~sh[7];
                        end
                     end
                     2'h1: scl_oe <= 1'b0;
                     2'h2: begin
                        if (ack_slot) begin
                           ack_q <= sda_s;
                        end else begin
                           sh <= {sh[6:0], sda_s};
                        end
                     end
                     default: begin
                        scl_oe <= 1'b1;
                        bitn   <= bitn + 4'h1;
                        if (ack_slot) begin
                           bitn <= 4'h0;
                           if (~is_rx & ack_q) begin
                              nack_err <= 1'b1;
                              state    <= MAG_HS_STOP;
                           end else if (is_rx & busy_st) begin
                              retry_q <= 1'b1;
                              state   <= MAG_HS_STOP;
                           end else if (last) begin
                              state <= MAG_HS_STOP;
                           end else begin
                              byten <= byten + 3'h1;
                              sh    <= pay_pick;
                           end
                        end
                     end
                  endcase
               end
            end
            MAG_HS_STOP: begin
               if (tick) begin
                  phase <= phase + 2'h1;
                  case (phase)
                     2'h0: sda_oe <= 1'b1;
                     2'h1: scl_oe <= 1'b0;
                     2'h2: sda_oe <= 1'b0;
                     default: begin
                        retry_q <= 1'b0;
                        state   <= retry_q ? MAG_HS_START : MAG_HS_IDLE;
                        done    <= ~retry_q;
                     end
                  endcase
               end
            end
            default: begin
               state  <= MAG_HS_IDLE;
               scl_oe <= 1'b0;
               sda_oe <= 1'b0;
            end
         endcase
      end
   end
endmodule

// ### mag_fifo.sv
// Purpose: Small flip-flop FIFO with valid/ready on both sides.
// Assumes: Single clock.
// Notes:   in_ready falls when full, so the writer must stall.
`timescale 1ns/1ps
module mag_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;
   wire wr_wrap = wr_ptr == AW'(DEPTH - 1);
   wire rd_wrap = rd_ptr == AW'(DEPTH - 1);

   assign in_ready  = count != (AW + 1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data  = store[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_wrap ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_wrap ? '0 : rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// ### mag_if.sv
// Purpose: Open-drain two-wire link between controller and sensor.
// Assumes: Both lines have a pull-up.
// Notes:   A line is low while any enable with a low output is set.
`timescale 1ns/1ps
interface mag_if;
   logic host_scl_oe;
   logic host_scl_out;
   logic host_sda_oe;
   logic host_sda_out;
   logic dev_scl_oe;
   logic dev_scl_out;
   logic dev_sda_oe;
   logic dev_sda_out;
   logic scl;
   logic sda;

   assign scl = (host_scl_oe ? host_scl_out : 1'b1) & (dev_scl_oe ? dev_scl_out : 1'b1);
   assign sda = (host_sda_oe ? host_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);

   modport host_mp (
      output host_scl_oe,
      output host_scl_out,
      output host_sda_oe,
      output host_sda_out,
      input  scl,
      input  sda
   );

   modport dev_mp (
      output dev_scl_oe,
      output dev_scl_out,
      output dev_sda_oe,
      output dev_sda_out,
      input  scl,
      input  sda
   );
endinterface

// ### mag_pkg.sv
// Purpose: Types shared by both ends of the magnetometer command link.
// Assumes: Nothing.
// Notes:   State codes are one-hot.
package mag_pkg;

   typedef enum logic [1:0] {
      MAG_OP_MEASURE  = 2'h0,
      MAG_OP_MEM_RD   = 2'h1,
      MAG_OP_MEM_WR   = 2'h2,
      MAG_OP_CHECKSUM = 2'h3
   } mag_op_type;

   typedef enum logic [5:0] {
      MAG_DS_IDLE  = 6'h01,
      MAG_DS_ADDR  = 6'h02,
      MAG_DS_WACK  = 6'h04,
      MAG_DS_WDATA = 6'h08,
      MAG_DS_RDATA = 6'h10,
      MAG_DS_RACK  = 6'h20
   } mag_dev_state_type;

   typedef enum logic [3:0] {
      MAG_HS_IDLE  = 4'h1,
      MAG_HS_START = 4'h2,
      MAG_HS_BIT   = 4'h4,
      MAG_HS_STOP  = 4'h8
   } mag_host_state_type;

endpackage

// ### mag_sensor_end.sv
// Purpose: Sensor end of the two-wire command link: slave protocol,
//          command decode, status byte and result bytes.
// Assumes: scl and sda come from another domain; user side is on clk.
// Notes:   Never stretches the clock; reads past the frame give 0xFF.
// What this block does
// - Answer at seven-bit address 16
// - Lines only pulled low, never driven high
// - Command 0xAA then stop starts measurement
// - Measurement read: status, field, temperature bytes
// - Controller acks each read byte but the last, and nacks a busy status byte
// - Status bits 7, 4, 3, 1 read zero
// - Status bit 6 shows supply good
// - Status bit 5 shows any command running
// - Status bit 2 shows checksum mismatch
// - Status bit 0 shows sensor saturated
// - Command 0x90 recomputes stored checksum
// - Controller repeats read while busy status
// - Command equal to address requests memory read
// - Memory read: status, data high, data low
// - Write 0x40 plus address, two bytes, stop
// - Command bit 6 marks memory write
// - Commands ignored while busy
`timescale 1ns/1ps
`include "mag_consts.svh"
module mag_sensor_end (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                reset,
   // Two-wire link
   mag_if.dev_mp                    link,
   // Command to the sensor core
   output logic                     cmd_valid,
   output mag_pkg::mag_op_type      cmd_op,
   output logic [5:0]               cmd_addr,
   output logic [15:0]              cmd_wdata,
   // Results and conditions from the sensor core
   input  wire logic                res_done,
   input  wire logic [23:0]         res_field,
   input  wire logic [23:0]         res_temp,
   input  wire logic [15:0]         res_mem,
   input  wire logic                res_saturated,
   input  wire logic                power_ok,
   input  wire logic                checksum_bad,
   // Visible state
   output logic                     busy
);
   import mag_pkg::*;

   mag_dev_state_type state;
   logic [1:0]        scl_sync;
   logic [1:0]        sda_sync;
   logic              scl_prev;
   logic              sda_prev;
   logic [3:0]        bit_cnt;
   logic [7:0]        rx_sh;
   logic [7:0]        tx_sh;
   logic              rw;
   logic              was_write;
   logic [2:0]        ridx;
   logic [1:0]        wcnt;
   logic [7:0]        wbytes [0:2];
   logic              sda_oe;
   mag_op_type        op_q;
   logic [23:0]       field_q;
   logic [23:0]       temp_q;
   logic [15:0]       mem_q;
   logic              sat_q;

   // Edge and condition detection on the synchronised lines
   wire scl_s     = scl_sync[1];
   wire sda_s     = sda_sync[1];
   wire scl_rise  = scl_s & ~scl_prev;
   wire scl_fall  = ~scl_s & scl_prev;
   wire start_det = scl_s & scl_prev & sda_prev & ~sda_s;
   wire stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;
   wire rx_state  = (state == MAG_DS_ADDR) | (state == MAG_DS_WDATA);
   wire byte_end  = scl_fall & (bit_cnt == 4'h8);
   wire addr_hit  = rx_sh[7:1] == `MAG_DEV_ADDR;

   // Status byte
   wire [7:0] status_byte = {1'b0,
                             power_ok,
                             busy,
                             2'b00,
                             checksum_bad,
                             1'b0,
                             sat_q};

   // Response selection by byte index
   wire [55:0] meas_frame = {status_byte, field_q, temp_q};
   wire [23:0] mem_frame  = {status_byte, mem_q};
   wire [7:0]  meas_pick  = meas_frame[6'd55 - {ridx, 3'b000} -: 8];
   wire [7:0]  mem_pick   = mem_frame[5'd23 - {ridx[1:0], 3'b000} -: 8];
   wire        meas_sel   = (op_q == MAG_OP_MEASURE) & (ridx < `MAG_MEAS_LEN);
   wire        mem_sel    = (op_q == MAG_OP_MEM_RD) & (ridx < `MAG_MEM_LEN);
   wire [7:0]  tx_byte    = meas_sel ? meas_pick :
                            mem_sel ? mem_pick :
                            (ridx == 3'h0) ? status_byte :
                            `MAG_IDLE_BYTE;

   // Command decode of the bytes of the last write transaction
   wire [7:0] cmd_byte  = wbytes[0];
   wire       is_meas   = cmd_byte == `MAG_CMD_MEASURE;
   wire       is_chk    = cmd_byte == `MAG_CMD_CHECKSUM;
   wire       is_mem    = ~cmd_byte[`MAG_MEM_CMD_BIT];
   wire       is_mem_wr = is_mem & cmd_byte[`MAG_MEM_WR_BIT];
   wire       is_mem_rd = is_mem & ~cmd_byte[`MAG_MEM_WR_BIT];
   wire       cmd_ok    = is_meas | is_chk | is_mem_rd |
                          (is_mem_wr & (wcnt == `MAG_WR_LEN));
   wire       issue     = stop_det & was_write & (wcnt != 2'h0) &
                          cmd_ok & ~busy;
   wire mag_op_type issue_op = is_meas ? MAG_OP_MEASURE :
                               is_chk ? MAG_OP_CHECKSUM :
                               is_mem_wr ? MAG_OP_MEM_WR :
                               MAG_OP_MEM_RD;

   // Open-drain only: the output value is always low
   assign link.dev_scl_oe  = 1'b0;
   assign link.dev_scl_out = 1'b0;
   assign link.dev_sda_out = 1'b0;
   assign link.dev_sda_oe  = sda_oe;

   always_ff @(posedge clk) begin
      if (reset) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], link.scl};
         sda_sync <= {sda_sync[0], link.sda};
         scl_prev <= scl_s;
         sda_prev <= sda_s;
      end
   end

   // Bit-level slave; data changes only after scl falls
   always_ff @(posedge clk) begin
      if (reset) begin
         state     <= MAG_DS_IDLE;
         bit_cnt   <= 4'h0;
         rx_sh     <= 8'h00;
         tx_sh     <= 8'h00;
         rw        <= 1'b0;
         was_write <= 1'b0;
         ridx      <= 3'h0;
         wcnt      <= 2'h0;
         sda_oe    <= 1'b0;
      end else if (start_det) begin
         state     <= MAG_DS_ADDR;
         bit_cnt   <= 4'h0;
         was_write <= 1'b0;
         ridx      <= 3'h0;
         wcnt      <= 2'h0;
         sda_oe    <= 1'b0;
      end else if (stop_det) begin
         state     <= MAG_DS_IDLE;
         was_write <= 1'b0;
         sda_oe    <= 1'b0;
      end else begin
         if (rx_state & scl_rise) begin
            rx_sh   <= {rx_sh[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
         end
         case (state)
            MAG_DS_ADDR: begin
               if (byte_end) begin
                  if (addr_hit) begin
                     state     <= MAG_DS_WACK;
                     sda_oe    <= 1'b1;
                     rw        <= rx_sh[0];
                     was_write <= ~rx_sh[0];
                  end else begin
                     state <= MAG_DS_IDLE;
                  end
               end
            end
            MAG_DS_WDATA: begin
               if (byte_end) begin
                  state  <= MAG_DS_WACK;
                  sda_oe <= 1'b1;
                  if (wcnt != `MAG_WR_LEN) begin
                     wcnt <= wcnt + 2'h1;
                  end
               end
            end
            MAG_DS_WACK, MAG_DS_RACK: begin
               if ((state == MAG_DS_RACK) & scl_rise) begin
                  if (sda_s) begin
                     state <= MAG_DS_IDLE;
                  end else if (ridx != 3'h7) begin
                     ridx <= ridx + 3'h1;
                  end
               end else if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  if (rw) begin
                     state  <= MAG_DS_RDATA;
                     sda_oe <= ~tx_byte[7];
                     tx_sh  <= {tx_byte[6:0], 1'b0};
                  end else begin
                     state  <= MAG_DS_WDATA;
                     sda_oe <= 1'b0;
                  end
               end
            end
            MAG_DS_RDATA: begin
               if (scl_fall) begin
                  if (bit_cnt == 4'h7) begin
                     state  <= MAG_DS_RACK;
                     sda_oe <= 1'b0;
                  end else begin
                     sda_oe  <= ~tx_sh[7];
                     tx_sh   <= {tx_sh[6:0], 1'b0};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            default: begin
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // Received command bytes; extra bytes beyond three are dropped
   always_ff @(posedge clk) begin
      if (reset) begin
         wbytes[0] <= 8'h00;
         wbytes[1] <= 8'h00;
         wbytes[2] <= 8'h00;
      end else if ((state == MAG_DS_WDATA) & byte_end & (wcnt != `MAG_WR_LEN)) begin
         wbytes[wcnt] <= rx_sh;
      end
   end

   // Command issue and result capture; busy covers the whole command
   always_ff @(posedge clk) begin
      if (reset) begin
         busy      <= 1'b0;
         op_q      <= MAG_OP_CHECKSUM;
         cmd_valid <= 1'b0;
         cmd_op    <= MAG_OP_MEASURE;
         cmd_addr  <= 6'h00;
         cmd_wdata <= 16'h0000;
         field_q   <= 24'h000000;
         temp_q    <= 24'h000000;
         mem_q     <= 16'h0000;
         sat_q     <= 1'b0;
      end else begin
         cmd_valid <= issue;
         if (issue) begin
            busy      <= 1'b1;
            op_q      <= issue_op;
            cmd_op    <= issue_op;
            cmd_addr  <= cmd_byte[5:0];
            cmd_wdata <= {wbytes[1], wbytes[2]};
         end else if (busy & res_done) begin
            busy <= 1'b0;
            if (op_q == MAG_OP_MEASURE) begin
               field_q <= res_field;
               temp_q  <= res_temp;
               sat_q   <= res_saturated;
            end
            if (op_q == MAG_OP_MEM_RD) begin
               mem_q <= res_mem;
            end
         end
      end
   end
endmodule

// ### tb_magnetometer_i2c_command_slave.sv
// Purpose: Runs commands and reads across the link between both ends.
// Assumes: Core model answers every command after a fixed delay.
// Notes:   The long core delay forces busy retries and dropped commands.
`timescale 1ns/1ps
module tb_magnetometer_i2c_command_slave;
   import mag_pkg::*;
   logic clk = 0, reset = 1, req_valid = 0, req_read = 0, rx_ready = 0;
   logic res_done = 0, checksum_bad = 0, req_ready, done, nack_err, rx_valid;
   logic cmd_valid, busy, pwr = 1, sat = 1;
   logic [2:0] req_len = 0;
   logic [23:0] req_bytes = 0;
   logic [7:0] rx_data;
   logic [7:0] meas [7] = '{8'h41, 8'h12, 8'h34, 8'h56, 8'hAB, 8'hCD, 8'hEF};
   mag_op_type cmd_op, lop;
   logic [5:0] cmd_addr, laddr;
   logic [15:0] cmd_wdata, lwd;
   int failures = 0, checks = 0, ncmd = 0, wcnt = 0, i, j;
   always #5 clk = ~clk;
   mag_if i_mag_if ();
   mag_ctrl_end #(.QUARTER_CYCLES(20)) i_mag_ctrl_end (.clk(clk), .reset(reset),
      .link(i_mag_if), .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read),
      .req_len(req_len), .req_bytes(req_bytes), .done(done), .nack_err(nack_err),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
   mag_sensor_end i_mag_sensor_end (.clk(clk), .reset(reset), .link(i_mag_if),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .res_done(res_done), .res_field(24'h123456), .res_temp(24'hABCDEF),
      .res_mem(16'hBEEF), .res_saturated(sat), .power_ok(pwr),
      .checksum_bad(checksum_bad), .busy(busy));
   mag_assertions i_mag_assertions (.clk(clk), .reset(reset),
      .host_scl_oe(i_mag_if.host_scl_oe), .host_scl_out(i_mag_if.host_scl_out),
      .host_sda_oe(i_mag_if.host_sda_oe), .host_sda_out(i_mag_if.host_sda_out),
      .dev_scl_oe(i_mag_if.dev_scl_oe), .dev_sda_oe(i_mag_if.dev_sda_oe),
      .dev_sda_out(i_mag_if.dev_sda_out), .scl(i_mag_if.scl));
   // Sensor core: answers 3000 clk after each command
   always @(posedge clk) begin
      #1;
      if (cmd_valid === 1'b1) begin
         ncmd++;
         lop = cmd_op;
         laddr = cmd_addr;
         lwd = cmd_wdata;
         wcnt = 3000;
      end else if (wcnt > 0) begin
         wcnt--;
      end
      res_done = (wcnt == 1);
   end
   task automatic results();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 30000) begin
         failures++;
         results();
      end
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic send(input logic rd, input logic [2:0] n, input logic [23:0] b);
      step();
      req_valid = 1;
      req_read = rd;
      req_len = n;
      req_bytes = b;
      for (i = 0; i < 30000 && req_ready !== 1'b1; i++) step();
      tmo(i);
      step();
      req_valid = 0;
   endtask
   task automatic wait_done();
      for (i = 0; i < 30000 && done !== 1'b1; i++) step();
      tmo(i);
   endtask
   task automatic pop(input logic [7:0] exp);
      for (i = 0; i < 30000 && rx_valid !== 1'b1; i++) step();
      tmo(i);
      check({16'h0000, rx_data}, {16'h0000, exp});
      rx_ready = 1;
      step();
      rx_ready = 0;
      step();
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #1 reset = 0;
      repeat (4) step();
      send(0, 3'h1, 24'hAA0000);
      wait_done();
      check(24'(lop), 24'(MAG_OP_MEASURE));
      check(24'(busy), 24'h1);
      send(0, 3'h1, 24'h050000);
      wait_done();
      check(24'(ncmd), 24'h1);
      // Second read lands on a nearly full FIFO, so the controller must stall
      send(1, 3'h7, 24'h0);
      wait_done();
      send(1, 3'h7, 24'h0);
      // Leave the FIFO full long enough that the controller holds scl low
      repeat (3000) step();
      check(24'(i_mag_if.scl), 24'h0);
      for (j = 0; j < 14; j++) pop(meas[j % 7]);
      wait_done();
      checksum_bad = 1;
      send(0, 3'h1, 24'h900000);
      wait_done();
      check(24'(lop), 24'(MAG_OP_CHECKSUM));
      send(1, 3'h2, 24'h0);
      pop(8'h45);
      pop(8'hFF);
      wait_done();
      checksum_bad = 0;
      send(0, 3'h1, 24'h050000);
      wait_done();
      check(24'({lop, laddr}), 24'({MAG_OP_MEM_RD, 6'h05}));
      send(1, 3'h3, 24'h0);
      pop(8'h41);
      pop(8'hBE);
      pop(8'hEF);
      wait_done();
      send(0, 3'h3, 24'h471234);
      wait_done();
      check({lop, laddr, lwd}, {MAG_OP_MEM_WR, 6'h07, 16'h1234});
      check(24'(nack_err), 24'h0);
      // Saturation is latched only by a measurement, so bit 0 stays set
      pwr = 0;
      sat = 0;
      send(1, 3'h1, 24'h0);
      pop(8'h01);
      wait_done();
      results();
   end
endmodule
